/* src/ptp_trigger_target_cascade.sv */
/*
 * Target-time compare and cascade control of trigger output unit 1.
 * Assumes a synchronous 16-bit register port, a system time that is
 * stable in the clock domain, and fire pulses from the other units.
 */
// Contract
// - Nanoseconds target: 16 low, 14 high bits.
// - Seconds target held as two 16-bit words.
// - Bit 15 joins unit to cascade chain.
// - Bit 14 marks unit as chain tail.
// - All cascaded, no tail: loop forever.
// - Bits 13:10 select upstream unit, default 0xf.
// - Bit 9 set: fire at once if late.
// - Bit 9 clear: wait for target time.
// - Enable self-clears after the trigger fires.
// - Soft reset restores defaults, halts cascade.
`timescale 1ns/1ps

module ptp_trigger_target_cascade (
  // Clock and reset.
  input  wire logic        clk_sys_i,
  input  wire logic        rstn_i,
  // Register port.
  input  wire logic [15:0] reg_addr_i,
  input  wire logic        reg_wr_i,
  input  wire logic        reg_rd_i,
  input  wire logic [15:0] reg_wdata_i,
  output logic      [15:0] reg_rdata_o,
  // System time clock.
  input  wire logic [31:0] sys_sec_i,
  input  wire logic [29:0] sys_ns_i,
  // Cascade neighbours: fire pulses of units 1..12, state of 2..12.
  input  wire logic [11:0] upstream_fire_i,
  input  wire logic [10:0] peer_cascade_i,
  input  wire logic [10:0] peer_tail_i,
  // Unit outputs.
  output logic             trig_fire_o,
  output logic             unit_enable_o,
  output logic             loop_forever_o
);

  // True when the system time is at or past the target time.
  function automatic logic time_reached(input logic [31:0] s,
                                        input logic [29:0] n,
                                        input logic [31:0] ts,
                                        input logic [29:0] tn);
    time_reached = {s, n} >= {ts, tn};
  endfunction : time_reached

  // Target words, configuration word and unit state.
  logic [15:0] ns_low_q,  ns_low_d;
  logic [13:0] ns_high_q, ns_high_d;
  logic [15:0] sec_low_q, sec_low_d;
  logic [15:0] sec_high_q, sec_high_d;
  logic [15:0] cfg_q,     cfg_d;
  logic        srst_q,    srst_d;    // Self-clearing soft reset.
  logic        reached_q, reached_d; // Compare result last cycle.
  logic        fire_q,    fire_d;
  logic        loop_q,    loop_d;
  logic [15:0] rdata_q,   rdata_d;
  ptp_trig_pkg::unit_state_type state_q, state_d;

  // Decoded helpers.
  logic [31:0] tgt_sec;      // Combined seconds target.
  logic [29:0] tgt_ns;       // Combined nanoseconds target.
  logic        reached;      // Compare result this cycle.
  logic        fire;         // Unit fires this cycle.
  logic [3:0]  up_sel;       // Upstream selector code.
  logic        up_fire;      // Selected upstream unit fired.
  logic        wr_enable;    // Enable word written.

  assign tgt_sec = {sec_high_q, sec_low_q};
  assign tgt_ns  = {ns_high_q, ns_low_q};
  assign reached = time_reached(sys_sec_i, sys_ns_i, tgt_sec, tgt_ns);
  assign up_sel  = cfg_q[ptp_trig_pkg::CFG_UP_MSB:ptp_trig_pkg::CFG_UP_LSB];
  assign wr_enable = reg_wr_i &&
                     (reg_addr_i == ptp_trig_pkg::OFS_OUTPUT_UNIT_ENABLE);

  // Codes at and above the unused boundary select no unit at all.
  always_comb begin
    up_fire = 1'b0;
    if (up_sel < ptp_trig_pkg::UP_CODE_UNUSED) begin
      up_fire = upstream_fire_i[up_sel];
    end
  end

  // Fire decision. With the now bit a late target fires at once;
  // without it only a crossing of the target counts, so a target that
  // is already past when armed waits rather than firing.
  always_comb begin
    fire = 1'b0;
    if (state_q == ptp_trig_pkg::ST_ARMED) begin
      if (cfg_q[ptp_trig_pkg::CFG_NOW_BIT]) begin
        fire = reached;
      end else begin
        fire = reached && !reached_q;
      end
    end
  end

  // Register writes, soft reset and unit state.
  always_comb begin
    ns_low_d   = ns_low_q;
    ns_high_d  = ns_high_q;
    sec_low_d  = sec_low_q;
    sec_high_d = sec_high_q;
    cfg_d      = cfg_q;
    state_d    = state_q;
    srst_d     = 1'b0;
    reached_d  = reached;
    fire_d     = fire;
    if (reg_wr_i) begin
      case (reg_addr_i)
        ptp_trig_pkg::OFS_TGT_NS_LOW:   ns_low_d = reg_wdata_i;
        ptp_trig_pkg::OFS_TGT_NS_HIGH: begin
          // The two reserved top bits are dropped here and read as zero.
          ns_high_d =
            reg_wdata_i[ptp_trig_pkg::NS_HIGH_BITS-1:0];
        end
        ptp_trig_pkg::OFS_TGT_SEC_LOW: sec_low_d = reg_wdata_i;
        ptp_trig_pkg::OFS_TGT_SEC_HIGH: begin
          sec_high_d = reg_wdata_i;
        end
        ptp_trig_pkg::OFS_CONFIG_FIRST: cfg_d = reg_wdata_i;
        ptp_trig_pkg::OFS_OUTPUT_UNIT_SOFT_RESET: begin
          srst_d = reg_wdata_i[ptp_trig_pkg::UNIT_BIT];
        end
        default: begin
          // Other offsets belong to other blocks or hold nothing.
        end
      endcase
    end
    // Enable clears itself on fire; a set in the same cycle wins.
    case (state_q)
      ptp_trig_pkg::ST_IDLE: begin
        if (cfg_q[ptp_trig_pkg::CFG_CASCADE_BIT] && up_fire) begin
          state_d = ptp_trig_pkg::ST_ARMED;
        end
      end
      ptp_trig_pkg::ST_ARMED: begin
        if (fire) begin
          state_d = ptp_trig_pkg::ST_IDLE;
        end
      end
      default: state_d = ptp_trig_pkg::ST_IDLE;
    endcase
    if (wr_enable) begin
      state_d = reg_wdata_i[ptp_trig_pkg::UNIT_BIT]
                ? ptp_trig_pkg::ST_ARMED : ptp_trig_pkg::ST_IDLE;
    end
    // Soft reset acts in the cycle after its write and beats all else.
    if (srst_q) begin
      ns_low_d   = ptp_trig_pkg::TGT_RESET;
      ns_high_d  = ptp_trig_pkg::TGT_RESET[13:0];
      sec_low_d  = ptp_trig_pkg::TGT_RESET;
      sec_high_d = ptp_trig_pkg::TGT_RESET;
      cfg_d      = ptp_trig_pkg::CFG_RESET;
      state_d    = ptp_trig_pkg::ST_IDLE;
      fire_d     = 1'b0;
    end
  end

  // Endless chain: every unit cascaded and none marked as tail. The
  // iteration counter outside reads this flag and stops counting.
  always_comb begin
    loop_d = cfg_q[ptp_trig_pkg::CFG_CASCADE_BIT] &&
             !cfg_q[ptp_trig_pkg::CFG_TAIL_BIT] &&
             (&peer_cascade_i) && !(|peer_tail_i) && !srst_q;
  end

  // Read data is captured on the read strobe, one cycle later.
  always_comb begin
    rdata_d = rdata_q;
    if (reg_rd_i) begin
      case (reg_addr_i)
        ptp_trig_pkg::OFS_TGT_NS_LOW:   rdata_d = ns_low_q;
        ptp_trig_pkg::OFS_TGT_NS_HIGH: begin
          rdata_d = {2'h0, ns_high_q};
        end
        ptp_trig_pkg::OFS_TGT_SEC_LOW:  rdata_d = sec_low_q;
        ptp_trig_pkg::OFS_TGT_SEC_HIGH: rdata_d = sec_high_q;
        ptp_trig_pkg::OFS_CONFIG_FIRST: rdata_d = cfg_q;
        ptp_trig_pkg::OFS_OUTPUT_UNIT_ENABLE: begin
          rdata_d = {15'h0000, state_q == ptp_trig_pkg::ST_ARMED};
        end
        default: rdata_d = 16'h0000; // Soft reset reads zero.
      endcase
    end
  end

  // All state registers on one edge.
  always_ff @(posedge clk_sys_i) begin
    if (!rstn_i) begin
      ns_low_q   <= ptp_trig_pkg::TGT_RESET;
      ns_high_q  <= ptp_trig_pkg::TGT_RESET[13:0];
      sec_low_q  <= ptp_trig_pkg::TGT_RESET;
      sec_high_q <= ptp_trig_pkg::TGT_RESET;
      cfg_q      <= ptp_trig_pkg::CFG_RESET;
      state_q    <= ptp_trig_pkg::ST_IDLE;
      srst_q     <= 1'b0;
      reached_q  <= 1'b0;
      fire_q     <= 1'b0;
      loop_q     <= 1'b0;
      rdata_q    <= 16'h0000;
    end else begin
      ns_low_q   <= ns_low_d;
      ns_high_q  <= ns_high_d;
      sec_low_q  <= sec_low_d;
      sec_high_q <= sec_high_d;
      cfg_q      <= cfg_d;
      state_q    <= state_d;
      srst_q     <= srst_d;
      reached_q  <= reached_d;
      fire_q     <= fire_d;
      loop_q     <= loop_d;
      rdata_q    <= rdata_d;
    end
  end

  assign reg_rdata_o    = rdata_q;
  assign trig_fire_o    = fire_q;
  assign unit_enable_o  = (state_q == ptp_trig_pkg::ST_ARMED);
  assign loop_forever_o = loop_q;

  // Checks of the unit's behaviour.
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!rstn_i);

  sequence rd_ns_high_s;
    reg_rd_i && reg_addr_i == ptp_trig_pkg::OFS_TGT_NS_HIGH;
  endsequence

  sequence armed_late_now_s;
    unit_enable_o && reached && cfg_q[ptp_trig_pkg::CFG_NOW_BIT];
  endsequence

  ns_high_reserved_a: assert property (
    rd_ns_high_s |=> reg_rdata_o[15:14] == 2'b00)
    else $error("Reserved nanosecond high bits read non-zero.");

  sec_write_hold_a: assert property (
    reg_wr_i && reg_addr_i == ptp_trig_pkg::OFS_TGT_SEC_HIGH && !srst_q
    |=> tgt_sec[31:16] == $past(reg_wdata_i))
    else $error("Seconds high word not stored.");

  cascade_arm_a: assert property (
    !unit_enable_o && !wr_enable && !srst_q && up_fire &&
    cfg_q[ptp_trig_pkg::CFG_CASCADE_BIT] |=> unit_enable_o)
    else $error("Cascade member did not arm on upstream fire.");

  tail_breaks_loop_a: assert property (
    cfg_q[ptp_trig_pkg::CFG_TAIL_BIT] |=> !loop_forever_o)
    else $error("Tail unit reported an endless chain.");

  loop_detect_a: assert property (
    cfg_q[ptp_trig_pkg::CFG_CASCADE_BIT] &&
    !cfg_q[ptp_trig_pkg::CFG_TAIL_BIT] && (&peer_cascade_i) &&
    !(|peer_tail_i) && !srst_q |=> loop_forever_o)
    else $error("Endless chain not flagged.");

  unused_code_a: assert property (
    up_sel >= ptp_trig_pkg::UP_CODE_UNUSED |-> !up_fire)
    else $error("Unused upstream code selected a unit.");

  fire_now_a: assert property (
    armed_late_now_s and !srst_q |=> trig_fire_o ##0 !unit_enable_o
    or $past(wr_enable))
    else $error("Late target with now bit did not fire at once.");

  wait_target_a: assert property (
    trig_fire_o && !$past(cfg_q[ptp_trig_pkg::CFG_NOW_BIT])
    |-> $past(reached) && !$past(reached_q))
    else $error("Trigger fired without target crossing.");

  self_clear_a: assert property (
    fire && !wr_enable && !srst_q |=> !unit_enable_o)
    else $error("Enable did not clear after fire.");

  soft_reset_a: assert property (
    srst_q |=> !unit_enable_o && cfg_q == ptp_trig_pkg::CFG_RESET
    ##1 !loop_forever_o)
    else $error("Soft reset did not restore defaults.");

  fire_reached_a: assert property (
    trig_fire_o |-> $past(reached) && $past(unit_enable_o))
    else $error("Fire without reached target or enable.");

endmodule : ptp_trigger_target_cascade

/* src/ptp_trig_pkg.sv */
/*
 * Constants for one precision-time trigger output unit: register
 * offsets, field positions, reset values and selector codes.
 * Assumes a 16-bit register port with byte offsets as printed.
 */
package ptp_trig_pkg;

  // Register offsets on the 16-bit register port.
  localparam logic [15:0] OFS_OUTPUT_UNIT_ENABLE     = 16'h0206;
  localparam logic [15:0] OFS_OUTPUT_UNIT_SOFT_RESET = 16'h0208;
  localparam logic [15:0] OFS_TGT_NS_LOW             = 16'h0220;
  localparam logic [15:0] OFS_TGT_NS_HIGH            = 16'h0222;
  localparam logic [15:0] OFS_TGT_SEC_LOW            = 16'h0224;
  localparam logic [15:0] OFS_TGT_SEC_HIGH           = 16'h0226;
  localparam logic [15:0] OFS_CONFIG_FIRST           = 16'h0228;

  // Bit of this unit inside the shared enable and soft reset words.
  localparam int unsigned UNIT_BIT = 0;

  // Nanosecond high word carries 14 writable bits.
  localparam int unsigned NS_HIGH_BITS = 14;

  // Field positions inside the first configuration word.
  localparam int unsigned CFG_CASCADE_BIT = 15;
  localparam int unsigned CFG_TAIL_BIT    = 14;
  localparam int unsigned CFG_UP_MSB      = 13;
  localparam int unsigned CFG_UP_LSB      = 10;
  localparam int unsigned CFG_NOW_BIT     = 9;

  // Reset values.
  localparam logic [15:0] TGT_RESET = 16'h0000;
  localparam logic [15:0] CFG_RESET = 16'h3c00;

  // Upstream selector: codes from this value upward select nothing.
  localparam logic [3:0] UP_CODE_UNUSED = 4'hc;

  // Number of trigger output units in the device.
  localparam int unsigned UNIT_COUNT = 12;

  // Unit control state.
  typedef enum logic [0:0] {
    ST_IDLE  = 1'b0,
    ST_ARMED = 1'b1
  } unit_state_type;

endpackage : ptp_trig_pkg

/* test/ptp_trigger_target_cascade_bench.sv */
/*
 * Self-checking bench for the trigger unit: registers, compare, cascade.
 * Assumes the design's own assertions; inputs change at falling edges.
 */
`timescale 1ns/1ps

module ptp_trigger_target_cascade_bench;

  logic        clk_sys_i = 1'b0;        // System clock, 10 MHz.
  logic        rstn_i = 1'b0;           // Synchronous reset, active low.
  logic [15:0] reg_addr_i = 16'h0000;   // Register byte offset.
  logic        reg_wr_i = 1'b0;         // Write strobe.
  logic        reg_rd_i = 1'b0;         // Read strobe.
  logic [15:0] reg_wdata_i = 16'h0000;  // Write data.
  logic [15:0] reg_rdata_o;             // Read data.
  logic [31:0] sys_sec_i = 32'h0;       // System time, seconds.
  logic [29:0] sys_ns_i = 30'h0;        // System time, nanoseconds.
  logic [11:0] upstream_fire_i = 12'h0; // Fire pulses of all units.
  logic [10:0] peer_cascade_i = 11'h0;  // Cascade bits of units 2..12.
  logic [10:0] peer_tail_i = 11'h0;     // Tail bits of units 2..12.
  logic        trig_fire_o;             // Trigger pulse.
  logic        unit_enable_o;           // Armed flag.
  logic        loop_forever_o;          // Endless chain flag.
  int          num_errors = 0;          // Mismatches seen.
  int          check_count = 0;         // Comparisons made.
  int          fire_cnt = 0;            // Trigger pulses counted.
  int          cycles = 0;              // Cycles since time zero.
  logic [15:0] lfsr = 16'heb10;         // Random state, fixed seed.
  logic [15:0] rd_val;                  // Last value read back.
  int          f0;                      // Pulse count before a step.

  ptp_trigger_target_cascade u_ptp_trigger_target_cascade (
    .clk_sys_i(clk_sys_i), .rstn_i(rstn_i), .reg_addr_i(reg_addr_i),
    .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_wdata_i(reg_wdata_i),
    .reg_rdata_o(reg_rdata_o), .sys_sec_i(sys_sec_i), .sys_ns_i(sys_ns_i),
    .upstream_fire_i(upstream_fire_i), .peer_cascade_i(peer_cascade_i),
    .peer_tail_i(peer_tail_i), .trig_fire_o(trig_fire_o),
    .unit_enable_o(unit_enable_o), .loop_forever_o(loop_forever_o));

  // Half period of 50 ns gives the 100 ns clock.
  always #50 clk_sys_i = ~clk_sys_i;

  // Pulses are counted at the edge, so a one-cycle pulse is never missed.
  always @(posedge clk_sys_i) begin
    cycles <= cycles + 1;
    if (trig_fire_o === 1'b1) begin
      fire_cnt <= fire_cnt + 1;
    end
    if (cycles == 5000) begin
      num_errors++;
      wrap_up();
    end
  end

  // Sixteen-bit shift register step; a plain bench stream, not the design's.
  function automatic logic [15:0] lfsr_next(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction : lfsr_next

  // Only the nanosecond high word loses its two reserved top bits.
  function automatic logic [15:0] exp_read(input logic [15:0] a,
                                           input logic [15:0] d);
    return (a == ptp_trig_pkg::OFS_TGT_NS_HIGH) ? (d & 16'h3fff) : d;
  endfunction : exp_read

  // Counts one comparison and reports a difference at once.
  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    check_count++;
    if (g !== e) begin
      num_errors++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  // One write: strobe raised for exactly one rising edge.
  task automatic wr(input logic [15:0] a, input logic [15:0] d);
    @(negedge clk_sys_i);
    reg_addr_i = a;
    reg_wdata_i = d;
    reg_wr_i = 1'b1;
    @(negedge clk_sys_i);
    reg_wr_i = 1'b0;
  endtask : wr

  // One read; the answer is settled by the next falling edge.
  task automatic rd(input logic [15:0] a);
    @(negedge clk_sys_i);
    reg_addr_i = a;
    reg_rd_i = 1'b1;
    @(negedge clk_sys_i);
    reg_rd_i = 1'b0;
    rd_val = reg_rdata_o;
  endtask : rd

  // Lets a number of falling edges pass.
  task automatic idle(input int n);
    repeat (n) @(negedge clk_sys_i);
  endtask : idle

  // Prints the counts and the verdict, then stops the run.
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : wrap_up

  // Main sequence: reset, registers, compare, cascade, soft reset.
  initial begin
    logic [15:0] a;
    logic [15:0] d;
    idle(8);
    rstn_i = 1'b1;
    for (int i = 0; i < 5; i++) begin
      rd(16'h0220 + 16'(2 * i));
      d = (i == 4) ? 16'h3c00 : 16'h0000;
      chk("reset value", d, rd_val);
    end
    rd(16'h022a);
    chk("unmapped read", 16'h0000, rd_val);
    // Random patterns, all-ones included, through the four target words.
    for (int i = 0; i < 12; i++) begin
      lfsr = lfsr_next(lfsr);
      a = 16'h0220 + 16'(2 * (i % 4));
      d = (i < 4) ? 16'hffff : lfsr;
      wr(a, d);
      rd(a);
      chk("target word", exp_read(a, d), rd_val);
    end
    // Configuration word keeps every written bit.
    for (int i = 0; i < 4; i++) begin
      lfsr = lfsr_next(lfsr);
      wr(ptp_trig_pkg::OFS_CONFIG_FIRST, lfsr);
      rd(ptp_trig_pkg::OFS_CONFIG_FIRST);
      chk("config word", lfsr, rd_val);
    end
    // Target 5 s 100 ns; time sits one nanosecond short.
    wr(16'h0220, 16'h0064);
    wr(16'h0222, 16'h0000);
    wr(16'h0224, 16'h0005);
    wr(16'h0226, 16'h0000);
    wr(ptp_trig_pkg::OFS_CONFIG_FIRST, 16'h3c00);
    sys_sec_i = 32'h5;
    sys_ns_i = 30'h63;
    f0 = fire_cnt;
    wr(ptp_trig_pkg::OFS_OUTPUT_UNIT_ENABLE, 16'h0001);
    idle(5);
    chk("early fire", f0, fire_cnt);
    chk("armed", 1'b1, unit_enable_o);
    sys_ns_i = 30'h64;
    idle(4);
    chk("fire at target", f0 + 1, fire_cnt);
    chk("enable cleared", 1'b0, unit_enable_o);
    // Already past and bit 9 clear: no crossing, so no pulse.
    sys_ns_i = 30'hc8;
    f0 = fire_cnt;
    wr(ptp_trig_pkg::OFS_OUTPUT_UNIT_ENABLE, 16'h0001);
    idle(5);
    chk("late wait", f0, fire_cnt);
    wr(ptp_trig_pkg::OFS_OUTPUT_UNIT_ENABLE, 16'h0000);
    // Bit 9 set: a late target fires straight away.
    wr(ptp_trig_pkg::OFS_CONFIG_FIRST, 16'h3e00);
    wr(ptp_trig_pkg::OFS_OUTPUT_UNIT_ENABLE, 16'h0001);
    idle(4);
    chk("fire now", f0 + 1, fire_cnt);
    chk("enable cleared", 1'b0, unit_enable_o);
    // Every selector code; the wrong neighbours fire first.
    sys_sec_i = 32'h0;
    sys_ns_i = 30'h0;
    for (int c = 0; c < 16; c++) begin
      wr(ptp_trig_pkg::OFS_CONFIG_FIRST, 16'h8000 | 16'(c << 10));
      upstream_fire_i = (c < 12) ? ~(12'h1 << c) : 12'hfff;
      idle(1);
      upstream_fire_i = 12'h000;
      idle(1);
      chk("wrong upstream", 1'b0, unit_enable_o);
      if (c < 12) begin
        upstream_fire_i = 12'h1 << c;
        idle(1);
        upstream_fire_i = 12'h000;
        idle(1);
        chk("upstream arms", 1'b1, unit_enable_o);
        wr(ptp_trig_pkg::OFS_OUTPUT_UNIT_ENABLE, 16'h0000);
      end
    end
    // Head of a ring of units one to three points back at unit three.
    wr(ptp_trig_pkg::OFS_CONFIG_FIRST, 16'h8800);
    upstream_fire_i = 12'h004;
    idle(1);
    upstream_fire_i = 12'h000;
    idle(1);
    chk("ring head arms", 1'b1, unit_enable_o);
    wr(ptp_trig_pkg::OFS_OUTPUT_UNIT_ENABLE, 16'h0000);
    // Out of the chain, the upstream pulse is ignored.
    wr(ptp_trig_pkg::OFS_CONFIG_FIRST, 16'h0000);
    upstream_fire_i = 12'h001;
    idle(1);
    upstream_fire_i = 12'h000;
    idle(1);
    chk("no cascade", 1'b0, unit_enable_o);
    // Endless chain only when all are in and none is the tail.
    wr(ptp_trig_pkg::OFS_CONFIG_FIRST, 16'h8000);
    peer_cascade_i = 11'h7ff;
    idle(3);
    chk("loop flag", 1'b1, loop_forever_o);
    lfsr = lfsr_next(lfsr);
    peer_tail_i = lfsr[10:0] | 11'h400;
    idle(3);
    chk("peer tail", 1'b0, loop_forever_o);
    peer_tail_i = 11'h000;
    peer_cascade_i = 11'h3ff;
    idle(3);
    chk("peer out", 1'b0, loop_forever_o);
    peer_cascade_i = 11'h7ff;
    wr(ptp_trig_pkg::OFS_CONFIG_FIRST, 16'hc000);
    idle(3);
    chk("own tail", 1'b0, loop_forever_o);
    wr(ptp_trig_pkg::OFS_CONFIG_FIRST, 16'h8000);
    wr(16'h0224, 16'h1234);
    idle(3);
    chk("loop again", 1'b1, loop_forever_o);
    // Soft reset stops the loop and restores every default.
    wr(ptp_trig_pkg::OFS_OUTPUT_UNIT_SOFT_RESET, 16'h0001);
    idle(3);
    chk("loop stopped", 1'b0, loop_forever_o);
    rd(ptp_trig_pkg::OFS_CONFIG_FIRST);
    chk("config default", 16'h3c00, rd_val);
    rd(16'h0224);
    chk("target default", 16'h0000, rd_val);
    rd(ptp_trig_pkg::OFS_OUTPUT_UNIT_SOFT_RESET);
    chk("soft reset clear", 16'h0000, rd_val);
    wrap_up();
  end

endmodule : ptp_trigger_target_cascade_bench
